// File: bench/sut_partner.sv
// sut_partner: remote serial party, one 8-bit frame sender and receiver
// assumes 16 clocks per bit, the baud register at its reset value
module sut_partner #(
  parameter int BIT_CLK = 16
) (
  input wire logic clk,
  input wire logic line_in,
  output logic line_out,
  input wire logic go,
  input wire logic [7:0] tx_byte,
  output logic [7:0] rx_byte,
  output int rx_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    line_out = 1'b1;
    rx_cnt = 0;
  end
  // low start, lsb first, one high stop, line rests high
  always @(posedge clk) begin
    if (go) begin
      line_out <= 1'b0;
      repeat (BIT_CLK) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        line_out <= tx_byte[i];
        repeat (BIT_CLK) @(posedge clk);
      end
      line_out <= 1'b1;
      repeat (BIT_CLK) @(posedge clk);
    end
  end
  // sample mid-bit so edge skew cannot flip a bit
  always begin
    @(negedge line_in);
    repeat (BIT_CLK / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CLK) @(posedge clk);
      rx_byte[i] = line_in;
    end
    repeat (BIT_CLK) @(posedge clk);
    rx_cnt = rx_cnt + 1;
  end
endmodule : sut_partner

// File: bench/sut_top_tb_top.sv
// sut_top_tb_top: directed bench for the serial transceiver
// assumes baud register left at reset value, clear-to-send low outside the flow control scenario
`include "sut_defines.svh"
module sut_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, wr, rd, go, txd, txd_oe, rts_n, sck, irq, dtx, drx, rxd, cts_n;
  logic [7:0] addr, p_tx, p_rx;
  logic [31:0] wdata, rdata, v;
  int failures, n_checks, p_cnt, k, n_sck, n_low;
  // shared wire rests high when nobody drives it
  wire logic line_w = txd_oe ? txd : 1'b1;
  sut_top u_sut_top(.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .rxd_i(rxd), .txd_i(line_w), .txd_o(txd), .txd_oe(txd_oe),
    .cts_n_i(cts_n), .rts_n_o(rts_n), .sck_o(sck), .irq(irq), .dma_tx_req(dtx),
    .dma_rx_req(drx));
  sut_partner u_sut_partner(.clk(clk), .line_in(line_w), .line_out(rxd), .go(go),
    .tx_byte(p_tx), .rx_byte(p_rx), .rx_cnt(p_cnt));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic end_sim;
    if (failures == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // a wait that runs out ends the run at once
  task automatic wait_ok(input string nm, input logic ok);
    chk(nm, 32'h0000_0001, 32'(ok));
    if (ok !== 1'b1) end_sim();
  endtask : wait_ok
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg
  task automatic send_byte(input logic [7:0] b);
    @(posedge clk);
    p_tx <= b;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    for (k = 0; k < 300 && irq !== 1'b1; k++) @(posedge clk);
    #1;
    wait_ok("irq raised", irq);
  endtask : send_byte
  task automatic t_reset;
    // the cts level bit reads high until its synchroniser has filled
    rd_reg(8'h20, v);
    chk("unmapped", 32'h0000_0000, v);
    rd_reg(`SUT_A_STS, v);
    chk("status", 32'h0000_000C, v);
    chk("line idle", 32'h0000_0001, 32'(txd));
  endtask : t_reset
  task automatic t_tx;
    wr_reg(`SUT_A_CTRL, 32'h0002_4003);
    wr_reg(`SUT_A_DAT, 32'h0000_00A5);
    n_sck = 0;
    for (k = 0; k < 400 && p_cnt == 0; k++) begin
      @(posedge clk);
      if (sck === 1'b1) n_sck++;
    end
    wait_ok("frame seen", p_cnt == 1);
    chk("tx byte", 32'h0000_00A5, 32'(p_rx));
    chk("sck pulses", 32'h0000_0040, 32'(n_sck));
    repeat (16) @(posedge clk);
    rd_reg(`SUT_A_STS, v);
    chk("tx done", 32'h0000_000C, v & 32'h0000_000C);
    chk("dma tx", 32'h0000_0001, 32'(dtx));
  endtask : t_tx
  task automatic t_rx;
    wr_reg(`SUT_A_CTRL, 32'h0004_1003);
    wr_reg(`SUT_A_IEN, 32'h0000_0010);
    send_byte(8'h3C);
    chk("rts busy", 32'h0000_0001, 32'(rts_n));
    chk("dma rx", 32'h0000_0001, 32'(drx));
    rd_reg(`SUT_A_DAT, v);
    chk("rx byte", 32'h0000_003C, v);
    repeat (2) @(posedge clk);
    #1;
    chk("irq after read", 32'h0000_0000, 32'(irq));
    chk("rts ready", 32'h0000_0000, 32'(rts_n));
  endtask : t_rx
  // bit 7 is the even parity slot, so 0x01 carries a wrong parity
  task automatic t_parity;
    wr_reg(`SUT_A_CTRL, 32'h0000_000B);
    wr_reg(`SUT_A_IEN, 32'h0000_0200);
    send_byte(8'h01);
    rd_reg(`SUT_A_STS, v);
    chk("parity flag", 32'h0000_0200, v & 32'h0000_0200);
    wr_reg(`SUT_A_ICLR, 32'h0000_0200);
    rd_reg(`SUT_A_STS, v);
    chk("parity clear", 32'h0000_0000, v & 32'h0000_0200);
    chk("irq cleared", 32'h0000_0000, 32'(irq));
  endtask : t_parity
  // clear-to-send high must hold a written word back
  task automatic t_cts;
    wr_reg(`SUT_A_CTRL, 32'h0000_2001);
    cts_n <= 1'b1;
    wr_reg(`SUT_A_DAT, 32'h0000_005A);
    repeat (40) @(posedge clk);
    rd_reg(`SUT_A_STS, v);
    chk("cts held", 32'h0000_0400, v & 32'h0000_0404);
    chk("cts change", 32'h0000_0001, v & 32'h0000_0001);
    @(posedge clk);
    cts_n <= 1'b0;
    for (k = 0; k < 400 && p_cnt < 2; k++) @(posedge clk);
    wait_ok("cts frame", p_cnt == 2);
    chk("cts byte", 32'h0000_005A, 32'(p_rx));
  endtask : t_cts
  // break on the shared wire, heard back by the own receiver
  task automatic t_brk;
    wr_reg(`SUT_A_IEN, 32'h0000_0002);
    wr_reg(`SUT_A_CTRL, 32'h0000_0883);
    wr_reg(`SUT_A_CMD, 32'h0000_0001);
    n_low = 0;
    for (k = 0; k < 300; k++) begin
      @(posedge clk);
      if (txd === 1'b0) n_low++;
    end
    chk("break low", 32'h0000_00D0, 32'(n_low));
    chk("wire released", 32'h0000_0000, 32'(txd_oe));
    rd_reg(`SUT_A_STS, v);
    chk("break flag", 32'h0000_0002, v & 32'h0000_0002);
    chk("break irq", 32'h0000_0001, 32'(irq));
  endtask : t_brk
  initial begin
    rst = 1'b1;
    {wr, rd, go, cts_n} = 4'h0;
    {addr, p_tx, wdata} = 48'h0000_0000_0000;
    failures = 0;
    n_checks = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_tx();
    t_rx();
    t_parity();
    t_cts();
    t_brk();
    end_sim();
  end
endmodule : sut_top_tb_top

// File: hw/sut_defines.svh
// sut_defines.svh: register offsets, field positions, reset values, bit timing counts
// assumes a single 100 MHz clock and the plain strobe register port of sut_top
`ifndef SUT_DEFINES_SVH
`define SUT_DEFINES_SVH
// ***************************************************************
// register offsets
// ***************************************************************
`define SUT_A_STS 8'h00
`define SUT_A_DAT 8'h04
`define SUT_A_BRR 8'h08
`define SUT_A_CTRL 8'h0C
`define SUT_A_GT 8'h10
`define SUT_A_IEN 8'h14
`define SUT_A_ICLR 8'h18
`define SUT_A_CMD 8'h1C
// ***************************************************************
// control fields
// ***************************************************************
`define SUT_C_TE 0
`define SUT_C_RE 1
`define SUT_C_M9 2
`define SUT_C_PCE 3
`define SUT_C_PS 4
`define SUT_C_STOP 5
`define SUT_C_LIN 7
`define SUT_C_LBDL 8
`define SUT_C_IREN 9
`define SUT_C_SCEN 10
`define SUT_C_HD 11
`define SUT_C_RTSE 12
`define SUT_C_CTSE 13
`define SUT_C_CLKEN 14
`define SUT_C_MUTE 15
`define SUT_C_WAKE 16
`define SUT_C_DMAT 17
`define SUT_C_DMAR 18
`define SUT_C_ADDR 20
// ***************************************************************
// status and interrupt fields
// ***************************************************************
`define SUT_S_CTSF 0
`define SUT_S_LBD 1
`define SUT_S_TXE 2
`define SUT_S_TC 3
`define SUT_S_RXNE 4
`define SUT_S_IDLE 5
`define SUT_S_ORE 6
`define SUT_S_FE 7
`define SUT_S_NE 8
`define SUT_S_PE 9
`define SUT_CLR_MASK 10'h3FB
// ***************************************************************
// reset values and timing counts
// ***************************************************************
`define SUT_FLG_RST 10'h00C
`define SUT_CTRL_RST 32'h0000_0000
`define SUT_BRR_RST 16'h0010
`define SUT_SUB 8'h10
`define SUT_SMP 4'h7
`define SUT_NB_SHORT 4'h8
`define SUT_NB_LONG 4'h9
`define SUT_IDLE_EXTRA 8'h02
`define SUT_BRK_BITS 8'h0D
`define SUT_LBD_SHORT 8'h0A
`define SUT_LBD_LONG 8'h0B
`define SUT_IR_PULSE 8'h03
`endif

// File: hw/sut_pkg.sv
// sut_pkg: state and mode types of the serial transceiver
// assumes sut_defines.svh supplies the numeric constants
package sut_pkg;
  typedef enum logic [2:0] {
    SUT_TX_IDLE = 3'h0,
    SUT_TX_START = 3'h1,
    SUT_TX_DATA = 3'h3,
    SUT_TX_STOP = 3'h2,
    SUT_TX_GUARD = 3'h6,
    SUT_TX_BRK = 3'h4
  } sut_tx_e;
  typedef enum logic [1:0] {
    SUT_RX_IDLE = 2'h0,
    SUT_RX_START = 2'h1,
    SUT_RX_DATA = 2'h3,
    SUT_RX_STOP = 2'h2
  } sut_rx_e;
  typedef enum logic [1:0] {
    SUT_STOP_1 = 2'h0,
    SUT_STOP_0H = 2'h1,
    SUT_STOP_2 = 2'h2,
    SUT_STOP_1H = 2'h3
  } sut_stop_e;
endpackage : sut_pkg

// File: hw/sut_top.sv
// sut_top: serial transceiver with baud generator, tx/rx engines and registers
// assumes one clock, a plain register port and pins that need synchronising
`include "sut_defines.svh"
module sut_top
  import sut_pkg::*;
#(
  parameter int AW = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [AW-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic rxd_i,
  input wire logic txd_i,
  output logic txd_o,
  output logic txd_oe,
  input wire logic cts_n_i,
  output logic rts_n_o,
  output logic sck_o,
  output logic irq,
  output logic dma_tx_req,
  output logic dma_rx_req
);
  // ***************************************************************
  // functions
  // ***************************************************************
  function automatic logic sut_par(input logic [8:0] d, input logic m9, input logic odd);
    sut_par = (m9 ? ^d[7:0] : ^d[6:0]) ^ odd;
  endfunction : sut_par

  function automatic logic sut_maj(input logic a, input logic b, input logic c);
    sut_maj = (a & b) | (a & c) | (b & c);
  endfunction : sut_maj

  // ***************************************************************
  // declarations
  // ***************************************************************
  logic [1:0] rx_sy, tx_sy, cts_sy;
  logic [31:0] ctrl_reg, rdata_reg, rd_val;
  logic [15:0] brr_reg;
  logic [7:0] gt_reg;
  logic [9:0] ien_reg, flg_reg, flg_next, evt, clr;
  logic [8:0] tdr_reg, rdr_reg, tx_word, rx_word;
  logic [11:0] bd_cnt_reg, mant_m1;
  logic [3:0] bd_acc_reg, nb;
  logic [4:0] acc_sum, ir_hold_reg;
  logic tick, cts_s, cts_d_reg, brk_pend_reg, mute_reg, mute_next;
  logic txd_reg, oe_reg, sck_reg, rts_reg, irq_reg, dmat_reg, dmar_reg;
  logic te, re, m9, pce, odd, lin, iren, scen, hd, ctse, clken, mute_en, wake;
  sut_stop_e stop_c;
  logic [7:0] stop_sub, brk_sub, tx_lim, lbd_lim, idle_lim;
  logic w_dat, w_brr, w_ctrl, w_gt, w_ien, w_iclr, w_cmd, r_dat;
  sut_tx_e tx_st, tx_st_next;
  logic [7:0] tx_cnt, tx_cnt_next, tx_bit, tx_bit_next;
  logic [8:0] tx_sh, tx_sh_next;
  logic tx_uend, tx_load, tx_end, brk_go, tx_val, cts_ok, tx_par;
  sut_rx_e rx_st, rx_st_next;
  logic [3:0] rx_cnt, rx_cnt_next, rx_bit, rx_bit_next;
  logic [8:0] rx_sh, rx_sh_next;
  logic rx_src, rx_eff, rx_last_reg, s0_reg, s1_reg, maj, noisy, nz_reg;
  logic rx_eval, rx_done, rx_ok, addr_fr, addr_hit, par_bad;
  logic [7:0] idle_cnt, lb_cnt;
  logic idle_arm_reg, idle_hit, lbd_hit;

  // ***************************************************************
  // pin synchronisers
  // ***************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_sy <= 2'h3;
      tx_sy <= 2'h3;
      cts_sy <= 2'h3;
    end else begin
      rx_sy <= {rx_sy[0], rxd_i};
      tx_sy <= {tx_sy[0], txd_i};
      cts_sy <= {cts_sy[0], cts_n_i};
    end
  end
  assign cts_s = cts_sy[1];

  // ***************************************************************
  // register port
  // ***************************************************************
  assign te = ctrl_reg[`SUT_C_TE];
  assign re = ctrl_reg[`SUT_C_RE];
  assign m9 = ctrl_reg[`SUT_C_M9];
  assign pce = ctrl_reg[`SUT_C_PCE];
  assign odd = ctrl_reg[`SUT_C_PS];
  assign stop_c = sut_stop_e'(ctrl_reg[`SUT_C_STOP +: 2]);
  assign lin = ctrl_reg[`SUT_C_LIN];
  assign iren = ctrl_reg[`SUT_C_IREN];
  assign scen = ctrl_reg[`SUT_C_SCEN];
  assign hd = ctrl_reg[`SUT_C_HD] | scen;
  assign ctse = ctrl_reg[`SUT_C_CTSE];
  assign clken = ctrl_reg[`SUT_C_CLKEN];
  assign mute_en = ctrl_reg[`SUT_C_MUTE];
  assign wake = ctrl_reg[`SUT_C_WAKE];
  assign w_dat = wr & (addr == `SUT_A_DAT);
  assign w_brr = wr & (addr == `SUT_A_BRR);
  assign w_ctrl = wr & (addr == `SUT_A_CTRL);
  assign w_gt = wr & (addr == `SUT_A_GT);
  assign w_ien = wr & (addr == `SUT_A_IEN);
  assign w_iclr = wr & (addr == `SUT_A_ICLR);
  assign w_cmd = wr & (addr == `SUT_A_CMD);
  assign r_dat = rd & (addr == `SUT_A_DAT);
  // write-only and unmapped offsets read as zero
  assign rd_val = (addr == `SUT_A_STS) ? {20'h0_0000, mute_reg, cts_s, flg_reg} :
                  (addr == `SUT_A_DAT) ? {23'h00_0000, rdr_reg} :
                  (addr == `SUT_A_BRR) ? {16'h0000, brr_reg} :
                  (addr == `SUT_A_CTRL) ? ctrl_reg :
                  (addr == `SUT_A_GT) ? {24'h00_0000, gt_reg} :
                  (addr == `SUT_A_IEN) ? {22'h00_0000, ien_reg} : 32'h0000_0000;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= `SUT_CTRL_RST;
      brr_reg <= `SUT_BRR_RST;
      gt_reg <= 8'h00;
      ien_reg <= 10'h000;
      tdr_reg <= 9'h000;
      rdata_reg <= 32'h0000_0000;
    end else begin
      if (w_ctrl) ctrl_reg <= wdata;
      if (w_brr) brr_reg <= wdata[15:0];
      if (w_gt) gt_reg <= wdata[7:0];
      if (w_ien) ien_reg <= wdata[9:0];
      if (w_dat) tdr_reg <= wdata[8:0];
      rdata_reg <= rd ? rd_val : 32'h0000_0000;
    end
  end

  // ***************************************************************
  // fractional baud generator, tick = 1/16 bit
  // ***************************************************************
  // mantissa in [15:4], sixteenths in [3:0]; carry stretches one period
  assign mant_m1 = (brr_reg[15:4] == 12'h000) ? 12'h000 : brr_reg[15:4] - 12'h001;
  assign acc_sum = {1'b0, bd_acc_reg} + {1'b0, brr_reg[3:0]};
  assign tick = (bd_cnt_reg == 12'h000);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bd_cnt_reg <= 12'h000;
      bd_acc_reg <= 4'h0;
    end else if (tick) begin
      bd_cnt_reg <= mant_m1 + {11'h000, acc_sum[4]};
      bd_acc_reg <= acc_sum[3:0];
    end else begin
      bd_cnt_reg <= bd_cnt_reg - 12'h001;
    end
  end

  // ***************************************************************
  // transmitter
  // ***************************************************************
  assign nb = m9 ? `SUT_NB_LONG : `SUT_NB_SHORT;
  assign tx_par = sut_par(tdr_reg, m9, odd);
  // parity replaces the word's top bit
  assign tx_word = !pce ? tdr_reg : m9 ? {tx_par, tdr_reg[7:0]} :
                   {1'b0, tx_par, tdr_reg[6:0]};
  // half and one-and-a-half stop only exist for smart cards
  assign stop_sub = (stop_c == SUT_STOP_2) ? (`SUT_SUB << 1) :
                    (stop_c == SUT_STOP_0H && scen) ? (`SUT_SUB >> 1) :
                    (stop_c == SUT_STOP_1H) ? (scen ? `SUT_SUB + (`SUT_SUB >> 1) :
                    (`SUT_SUB << 1)) : `SUT_SUB;
  assign brk_sub = `SUT_BRK_BITS * `SUT_SUB;
  assign tx_lim = (tx_st == SUT_TX_BRK) ? brk_sub :
                  (tx_st == SUT_TX_STOP) ? stop_sub : `SUT_SUB;
  assign tx_uend = tick & (tx_cnt == tx_lim - 8'h01);
  assign cts_ok = !ctse | !cts_s;
  assign tx_val = !((tx_st == SUT_TX_START) | (tx_st == SUT_TX_BRK) |
                  ((tx_st == SUT_TX_DATA) & !tx_sh[0]));

  always_comb begin
    tx_st_next = tx_st;
    tx_cnt_next = tick ? tx_cnt + 8'h01 : tx_cnt;
    tx_bit_next = tx_bit;
    tx_sh_next = tx_sh;
    tx_load = 1'b0;
    tx_end = 1'b0;
    brk_go = 1'b0;
    case (tx_st)
      SUT_TX_IDLE: begin
        tx_cnt_next = 8'h00;
        if (te && brk_pend_reg) begin
          tx_st_next = SUT_TX_BRK;
          brk_go = 1'b1;
        end else if (te && !flg_reg[`SUT_S_TXE] && cts_ok) begin
          tx_st_next = SUT_TX_START;
          tx_sh_next = tx_word;
          tx_load = 1'b1;
        end
      end
      SUT_TX_START: begin
        if (tx_uend) begin
          tx_st_next = SUT_TX_DATA;
          tx_cnt_next = 8'h00;
          tx_bit_next = 8'h00;
        end
      end
      SUT_TX_DATA: begin
        if (tx_uend) begin
          tx_cnt_next = 8'h00;
          tx_sh_next = {1'b0, tx_sh[8:1]};
          tx_bit_next = tx_bit + 8'h01;
          if (tx_bit == {4'h0, nb} - 8'h01) tx_st_next = SUT_TX_STOP;
        end
      end
      SUT_TX_STOP: begin
        if (tx_uend) begin
          tx_cnt_next = 8'h00;
          tx_bit_next = 8'h00;
          if (scen && gt_reg != 8'h00) begin
            tx_st_next = SUT_TX_GUARD;
          end else begin
            tx_st_next = SUT_TX_IDLE;
            tx_end = 1'b1;
          end
        end
      end
      SUT_TX_GUARD: begin
        if (tx_uend) begin
          tx_cnt_next = 8'h00;
          tx_bit_next = tx_bit + 8'h01;
          if (tx_bit == gt_reg - 8'h01) begin
            tx_st_next = SUT_TX_IDLE;
            tx_end = 1'b1;
          end
        end
      end
      SUT_TX_BRK: begin
        if (tx_uend) begin
          tx_cnt_next = 8'h00;
          tx_st_next = SUT_TX_STOP;
        end
      end
      default: tx_st_next = SUT_TX_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_st <= SUT_TX_IDLE;
      tx_cnt <= 8'h00;
      tx_bit <= 8'h00;
      tx_sh <= 9'h000;
      brk_pend_reg <= 1'b0;
    end else begin
      tx_st <= tx_st_next;
      tx_cnt <= tx_cnt_next;
      tx_bit <= tx_bit_next;
      tx_sh <= tx_sh_next;
      brk_pend_reg <= (brk_pend_reg & !brk_go) | (w_cmd & wdata[0]);
    end
  end

  // ***************************************************************
  // receiver
  // ***************************************************************
  // the shared wire is heard on the tx pin in single wire modes
  assign rx_src = hd ? tx_sy[1] : rx_sy[1];
  // an infrared pulse holds a zero for one bit time
  assign rx_eff = iren ? !(rx_src | (ir_hold_reg != 5'h00)) : rx_src;
  assign rx_eval = tick & (rx_cnt == `SUT_SMP + 4'h2);
  assign maj = sut_maj(s0_reg, s1_reg, rx_eff);
  assign noisy = !((s0_reg == s1_reg) && (s1_reg == rx_eff));

  always_comb begin
    rx_st_next = rx_st;
    rx_cnt_next = tick ? rx_cnt + 4'h1 : rx_cnt;
    rx_bit_next = rx_bit;
    rx_sh_next = rx_sh;
    rx_done = 1'b0;
    case (rx_st)
      SUT_RX_IDLE: begin
        rx_cnt_next = 4'h0;
        if (rx_last_reg && !rx_eff) rx_st_next = SUT_RX_START;
      end
      SUT_RX_START: begin
        if (rx_eval && maj) begin
          rx_st_next = SUT_RX_IDLE;
        end else if (tick && rx_cnt == 4'hF) begin
          rx_st_next = SUT_RX_DATA;
          rx_bit_next = 4'h0;
        end
      end
      SUT_RX_DATA: begin
        if (rx_eval) rx_sh_next = {maj, rx_sh[8:1]};
        if (tick && rx_cnt == 4'hF) begin
          rx_bit_next = rx_bit + 4'h1;
          if (rx_bit == nb - 4'h1) rx_st_next = SUT_RX_STOP;
        end
      end
      SUT_RX_STOP: begin
        // only the first stop bit is checked, so the next start is caught early
        if (rx_eval) begin
          rx_st_next = SUT_RX_IDLE;
          rx_done = 1'b1;
        end
      end
      default: rx_st_next = SUT_RX_IDLE;
    endcase
    if (!re) rx_st_next = SUT_RX_IDLE;
  end

  assign rx_word = m9 ? rx_sh : {1'b0, rx_sh[8:1]};
  assign par_bad = pce & (sut_par(rx_word, m9, odd) != (m9 ? rx_word[8] : rx_word[7]));
  assign addr_fr = m9 ? rx_word[8] : rx_word[7];
  assign addr_hit = (rx_word[3:0] == ctrl_reg[`SUT_C_ADDR +: 4]);
  assign mute_next = !mute_en ? 1'b0 :
                     (rx_done & addr_fr & !addr_hit) ? 1'b1 :
                     (rx_done & addr_fr & addr_hit & wake) ? 1'b0 :
                     (idle_hit & !wake) ? 1'b0 : mute_reg;
  assign rx_ok = rx_done & !mute_next;
  assign idle_lim = ({4'h0, nb} + `SUT_IDLE_EXTRA) * `SUT_SUB;
  assign idle_hit = tick & rx_eff & (rx_st == SUT_RX_IDLE) &
                    (idle_cnt == idle_lim - 8'h01) & (idle_arm_reg | mute_reg);
  assign lbd_lim = (ctrl_reg[`SUT_C_LBDL] ? `SUT_LBD_LONG : `SUT_LBD_SHORT) * `SUT_SUB;
  assign lbd_hit = lin & tick & !rx_eff & (lb_cnt == lbd_lim - 8'h01);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_st <= SUT_RX_IDLE;
      rx_cnt <= 4'h0;
      rx_bit <= 4'h0;
      rx_sh <= 9'h000;
      rx_last_reg <= 1'b1;
      s0_reg <= 1'b1;
      s1_reg <= 1'b1;
      nz_reg <= 1'b0;
      ir_hold_reg <= 5'h00;
      mute_reg <= 1'b0;
      rdr_reg <= 9'h000;
    end else begin
      rx_st <= rx_st_next;
      rx_cnt <= rx_cnt_next;
      rx_bit <= rx_bit_next;
      rx_sh <= rx_sh_next;
      rx_last_reg <= rx_eff;
      if (tick && rx_cnt == `SUT_SMP) s0_reg <= rx_eff;
      if (tick && rx_cnt == `SUT_SMP + 4'h1) s1_reg <= rx_eff;
      if (rx_st == SUT_RX_IDLE) nz_reg <= 1'b0;
      else if (rx_eval && noisy) nz_reg <= 1'b1;
      if (rx_src) ir_hold_reg <= 5'h0F;
      else if (tick && ir_hold_reg != 5'h00) ir_hold_reg <= ir_hold_reg - 5'h01;
      mute_reg <= mute_next;
      // an overrun keeps the unread word
      if (rx_ok && (!flg_reg[`SUT_S_RXNE] || r_dat)) rdr_reg <= rx_word;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idle_cnt <= 8'h00;
      lb_cnt <= 8'h00;
      idle_arm_reg <= 1'b0;
    end else begin
      if (!rx_eff || rx_st != SUT_RX_IDLE) idle_cnt <= 8'h00;
      else if (tick && idle_cnt != 8'hFF) idle_cnt <= idle_cnt + 8'h01;
      if (rx_eff) lb_cnt <= 8'h00;
      else if (tick && lb_cnt != 8'hFF) lb_cnt <= lb_cnt + 8'h01;
      idle_arm_reg <= (idle_arm_reg & !idle_hit) | rx_done;
    end
  end

  // ***************************************************************
  // flags, interrupt, dma and pins
  // ***************************************************************
  assign evt[`SUT_S_CTSF] = ctse & (cts_s != cts_d_reg);
  assign evt[`SUT_S_LBD] = lbd_hit;
  assign evt[`SUT_S_TXE] = tx_load;
  assign evt[`SUT_S_TC] = tx_end & flg_reg[`SUT_S_TXE];
  assign evt[`SUT_S_RXNE] = rx_ok;
  assign evt[`SUT_S_IDLE] = idle_hit & !mute_next;
  assign evt[`SUT_S_ORE] = rx_ok & flg_reg[`SUT_S_RXNE] & !r_dat;
  assign evt[`SUT_S_FE] = rx_ok & !maj;
  assign evt[`SUT_S_NE] = rx_ok & (nz_reg | noisy);
  assign evt[`SUT_S_PE] = rx_ok & par_bad;
  assign clr = (w_iclr ? (wdata[9:0] & `SUT_CLR_MASK) : 10'h000) |
               (r_dat ? (10'h001 << `SUT_S_RXNE) : 10'h000) |
               (w_dat ? ((10'h001 << `SUT_S_TXE) | (10'h001 << `SUT_S_TC)) : 10'h000);
  // a flag set in the cycle of its clear stays set
  assign flg_next = (flg_reg & ~clr) | evt;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flg_reg <= `SUT_FLG_RST;
      cts_d_reg <= 1'b1;
      irq_reg <= 1'b0;
      txd_reg <= 1'b1;
      oe_reg <= 1'b1;
      sck_reg <= 1'b0;
      rts_reg <= 1'b0;
      dmat_reg <= 1'b0;
      dmar_reg <= 1'b0;
    end else begin
      flg_reg <= flg_next;
      cts_d_reg <= cts_s;
      irq_reg <= |(flg_reg & ien_reg);
      txd_reg <= iren ? (!tx_val & (tx_cnt < `SUT_IR_PULSE)) : tx_val;
      oe_reg <= !hd | (tx_st != SUT_TX_IDLE);
      sck_reg <= clken & (tx_st == SUT_TX_DATA) & tx_cnt[3];
      rts_reg <= ctrl_reg[`SUT_C_RTSE] & flg_reg[`SUT_S_RXNE];
      dmat_reg <= ctrl_reg[`SUT_C_DMAT] & te & flg_reg[`SUT_S_TXE];
      dmar_reg <= ctrl_reg[`SUT_C_DMAR] & flg_reg[`SUT_S_RXNE];
    end
  end
  assign rdata = rdata_reg;
  assign txd_o = txd_reg;
  assign txd_oe = oe_reg;
  assign sck_o = sck_reg;
  assign rts_n_o = rts_reg;
  assign irq = irq_reg;
  assign dma_tx_req = dmat_reg;
  assign dma_rx_req = dmar_reg;

  // ***************************************************************
  // assertions
  // ***************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_start_low: assert property ((tx_st == SUT_TX_START) && !iren |=> !txd_o)
    else $error("start bit not low");
  a_stop_high: assert property ((tx_st == SUT_TX_STOP) && !iren |=> txd_o)
    else $error("stop bit not high");
  a_brk_len: assert property ((tx_st == SUT_TX_BRK) && (tx_st_next != SUT_TX_BRK)
    |-> tx_cnt == brk_sub - 8'h01) else $error("break length wrong");
  a_cts_hold: assert property ((tx_st == SUT_TX_IDLE) && ctse && cts_s
    |=> tx_st != SUT_TX_START) else $error("sent while cts deasserted");
  a_hd_release: assert property (hd && (tx_st == SUT_TX_IDLE) |=> !txd_oe)
    else $error("line driven while idle");
  a_ir_pulse: assert property (iren && $past(iren) && txd_o
    |-> $past(tx_cnt) < `SUT_IR_PULSE) else $error("ir pulse too long");
  a_irq_level: assert property (irq == $past(|(flg_reg & ien_reg)))
    else $error("irq not tied to flags");
  a_mute_quiet: assert property (rx_done && mute_reg && mute_next
    |=> !$rose(flg_reg[`SUT_S_RXNE])) else $error("muted receiver flagged");
  a_dma_rx: assert property (dma_rx_req |-> $past(flg_reg[`SUT_S_RXNE]))
    else $error("rx dma without data");
  a_te_off: assert property (!te && (tx_st == SUT_TX_IDLE) |=> tx_st == SUT_TX_IDLE)
    else $error("tx left idle while disabled");
  c_tx_frame: cover property (tx_end ##[1:300] tx_load);
  c_rx_par: cover property (rx_ok && par_bad);
  c_lin_brk: cover property (lbd_hit);
endmodule : sut_top
